/* File: logic/chg_pkg.sv */
// Constants, field layout and types of the charge control block
package chg_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLOOR = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_FAULT = 8'h0C;
  localparam logic [7:0] OFS_TERMINATION_CURRENT_THRESHOLD = 8'h10;
  localparam int CTRL_INH_B = 0;
  localparam int CTRL_DBL_B = 1;
  localparam int CTRL_TEN_B = 2;
  localparam int CTRL_RST_B = 3;
  localparam int FLOOR_EN_B = 3;
  localparam int FLOOR_W = 3;
  localparam int TERMINATION_CURRENT_THRESHOLD_W = 7;
  localparam logic [2:0] CTRL_RST = 3'h4;
  localparam logic [3:0] FLOOR_RST = 4'h0;
  localparam logic [6:0] TERMINATION_CURRENT_THRESHOLD_RST = 7'h13;
  localparam logic [6:0] TERMINATION_CURRENT_THRESHOLD_MAX = 7'h49;
  localparam logic [15:0] TERMINATION_CURRENT_THRESHOLD_STEP_UA = 16'h01F4;
  localparam logic [4:0] PCT_STEP = 5'h05;
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_FLOOR_B = 3;
  localparam int STAT_SUPP_B = 4;
  localparam int STAT_DFLT_B = 5;
  localparam int STAT_HALF_B = 6;
  localparam int FLT_OVP_B = 0;
  localparam int FLT_INPUT_UNDERVOLTAGE_FAULT_B = 1;
  localparam int IN_INPUT_UNDERVOLTAGE_FAULT = 0;
  localparam int IN_SLEEP = 1;
  localparam int IN_OVP = 2;
  localparam int IN_FLOW = 3;
  localparam int IN_BREG = 4;
  localparam int IN_TERMINATION_CURRENT_THRESHOLD = 5;
  localparam int IN_RECHG = 6;
  localparam int IN_SUP1 = 7;
  localparam int IN_SUP2 = 8;
  localparam int IN_INPUT_LIMIT_SETTING = 9;
  localparam int IN_FLOOP = 10;
  localparam int IN_CD = 11;
  localparam int IN_GSET = 12;
  localparam int IN_GLIM = 13;
  localparam int IN_GTRM = 14;
  localparam int IN_PCT = 15;
  localparam int IN_N = 17;
  localparam int CLK_MHZ = 200;
  localparam int PULSE_US = 128;
  localparam int OVP_DGL_US = 30;
  localparam int INPUT_UNDERVOLTAGE_FAULT_DGL_US = 30;
  localparam int CNT_W = 16;
  typedef enum logic [2:0] {
    ST_NOIN, ST_INH, ST_CC, ST_CV, ST_DONE, ST_FAULT
  } state_type;
  typedef enum logic [1:0] {LP_CC, LP_CV, LP_INPUT_LIMIT_SETTING, LP_FLOOR} loop_type;
endpackage

/* File: logic/charge_ctrl.sv */
// Charge cycle, loop tracking, fault and default-mode control with APB
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module charge_ctrl
  import chg_pkg::*;
#(
  parameter int unsigned PULSE_CYC = PULSE_US * CLK_MHZ,
  parameter int unsigned OVP_DGL_CYC = OVP_DGL_US * CLK_MHZ,
  parameter int unsigned INPUT_UNDERVOLTAGE_FAULT_DGL_CYC = INPUT_UNDERVOLTAGE_FAULT_DGL_US * CLK_MHZ
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic vin_input_undervoltage_fault_ok_i,
  input wire logic vin_sleep_ok_i,
  input wire logic input_overvoltage_fault_i,
  input wire logic vin_below_floor_i,
  input wire logic bat_at_reg_i,
  input wire logic ichg_at_term_i,
  input wire logic bat_above_rechg_i,
  input wire logic mid_below_sup_entry_i,
  input wire logic mid_above_sup_exit_i,
  input wire logic input_limit_setting_loop_i,
  input wire logic floor_loop_i,
  input wire logic charge_disable_pin_i,
  input wire logic fast_charge_setting_gnd_i,
  input wire logic input_limit_setting_gnd_i,
  input wire logic termination_current_threshold_gnd_i,
  input wire logic [1:0] term_pct_sel_i,
  output logic charge_en_o,
  output logic discharge_sw_o,
  output logic int_o,
  output logic timer_half_o,
  output logic timer_extend_o,
  output loop_type loop_o,
  output logic floor_en_o,
  output logic [FLOOR_W-1:0] floor_code_o,
  output logic [15:0] term_ua_o,
  output logic [15:0] precharge_ua_o,
  output logic [4:0] term_pct_o,
  output logic use_reg_fast_charge_setting_o,
  output logic use_reg_input_limit_setting_o,
  output logic use_reg_termination_current_threshold_o
);

  function automatic logic [15:0] termination_current_threshold_ua(input logic [6:0] code);
    logic [6:0] c;
    c = (code > TERMINATION_CURRENT_THRESHOLD_MAX) ? TERMINATION_CURRENT_THRESHOLD_MAX : code;
    return 16'((c + 7'h01) * TERMINATION_CURRENT_THRESHOLD_STEP_UA);
  endfunction

  function automatic logic [4:0] pct_of(input logic [1:0] sel);
    return 5'(({3'h0, sel} + 5'h01) * PCT_STEP);
  endfunction

  // Input synchroniser: a change counts once stages two and three agree
  logic [IN_N-1:0] raw, s1_r, s2_r, s3_r, f_r, f_nxt;
  assign raw = {term_pct_sel_i, termination_current_threshold_gnd_i, input_limit_setting_gnd_i, fast_charge_setting_gnd_i,
    charge_disable_pin_i, floor_loop_i, input_limit_setting_loop_i,
    mid_above_sup_exit_i, mid_below_sup_entry_i, bat_above_rechg_i,
    ichg_at_term_i, bat_at_reg_i, vin_below_floor_i,
    input_overvoltage_fault_i, vin_sleep_ok_i, vin_input_undervoltage_fault_ok_i};
  always_comb
  begin
    f_nxt = (s2_r & s3_r) | (f_r & (s2_r ^ s3_r));
  end
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      f_r <= '0;
    end
    else if (ce_i)
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= f_nxt;
    end
  end

  logic input_undervoltage_fault_ok, ovp_s, supp_in, supp_out, input_limit_setting_l, floor_l;
  assign input_undervoltage_fault_ok = f_r[IN_INPUT_UNDERVOLTAGE_FAULT];
  assign ovp_s = f_r[IN_OVP];
  assign supp_in = f_r[IN_SUP1];
  assign supp_out = f_r[IN_SUP2];
  assign input_limit_setting_l = f_r[IN_INPUT_LIMIT_SETTING];
  assign floor_l = f_r[IN_FLOOP];

  // Fault detection and interrupt pulse
  logic ovp_act_r, ovp_act_nxt, input_undervoltage_fault_act_r, input_undervoltage_fault_act_nxt;
  logic [CNT_W-1:0] ocnt_r, ocnt_nxt, ucnt_r, ucnt_nxt;
  logic [CNT_W-1:0] pcnt_r, pcnt_nxt;
  logic [1:0] fault_r, fault_nxt;
  logic int_r, int_nxt, ovp_ev, input_undervoltage_fault_ev, rd_fault;
  always_comb
  begin
    ovp_act_nxt = ovp_act_r;
    ocnt_nxt = '0;
    ovp_ev = ovp_s & !ovp_act_r;
    if (ovp_s)
      ovp_act_nxt = 1'b1;
    else if (ovp_act_r)
    begin
      // Hold the fault until the input stays clean for the deglitch time
      ocnt_nxt = ocnt_r + 1'b1;
      if (ocnt_r == CNT_W'(OVP_DGL_CYC - 1))
        ovp_act_nxt = 1'b0;
    end
    ucnt_nxt = '0;
    input_undervoltage_fault_act_nxt = input_undervoltage_fault_act_r & !input_undervoltage_fault_ok;
    input_undervoltage_fault_ev = 1'b0;
    if (!input_undervoltage_fault_ok && !input_undervoltage_fault_act_r)
    begin
      ucnt_nxt = ucnt_r + 1'b1;
      if (ucnt_r == CNT_W'(INPUT_UNDERVOLTAGE_FAULT_DGL_CYC - 1))
      begin
        input_undervoltage_fault_ev = 1'b1;
        input_undervoltage_fault_act_nxt = 1'b1;
        ucnt_nxt = '0;
      end
    end
    // Set wins over a read in the same cycle
    fault_nxt[FLT_OVP_B] = ovp_ev | (fault_r[FLT_OVP_B] &
      (!rd_fault | ovp_s));
    fault_nxt[FLT_INPUT_UNDERVOLTAGE_FAULT_B] = input_undervoltage_fault_ev | (fault_r[FLT_INPUT_UNDERVOLTAGE_FAULT_B] &
      (!rd_fault | !input_undervoltage_fault_ok));
    pcnt_nxt = pcnt_r;
    // Events inside a running pulse are absorbed, never stretching it
    if (pcnt_r == '0 && (ovp_ev || input_undervoltage_fault_ev))
      pcnt_nxt = CNT_W'(PULSE_CYC);
    else if (pcnt_r != '0)
      pcnt_nxt = pcnt_r - 1'b1;
    int_nxt = pcnt_nxt != '0;
  end
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ovp_act_r <= 1'b0;
      input_undervoltage_fault_act_r <= 1'b0;
      ocnt_r <= '0;
      ucnt_r <= '0;
      pcnt_r <= '0;
      fault_r <= '0;
      int_r <= 1'b0;
    end
    else if (ce_i)
    begin
      ovp_act_r <= ovp_act_nxt;
      input_undervoltage_fault_act_r <= input_undervoltage_fault_act_nxt;
      ocnt_r <= ocnt_nxt;
      ucnt_r <= ucnt_nxt;
      pcnt_r <= pcnt_nxt;
      fault_r <= fault_nxt;
      int_r <= int_nxt;
    end
  end
  assign int_o = int_r;

  // APB slave and host registers
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [3:0] floor_r, floor_nxt;
  logic [TERMINATION_CURRENT_THRESHOLD_W-1:0] termination_current_threshold_r, termination_current_threshold_nxt;
  logic dflt_r, dflt_nxt, rdy_r, rdy_nxt, err_r, err_nxt;
  logic [31:0] rdata_r, rdata_nxt, stat_w;
  logic wr_go, rd_go, valid, valid_r, mapped, hw_rst;
  state_type state_r, state_nxt;
  logic supp_r, floor_flag_r, half_r;
  assign wr_go = psel_i & penable_i & pwrite_i & rdy_r;
  assign rd_go = psel_i & penable_i & !pwrite_i & rdy_r;
  assign rd_fault = rd_go & (paddr_i == OFS_FAULT);
  assign hw_rst = wr_go & (paddr_i == OFS_CTRL) & pwdata_i[CTRL_RST_B];
  assign mapped = paddr_i inside {OFS_CTRL, OFS_FLOOR, OFS_STAT,
    OFS_FAULT, OFS_TERMINATION_CURRENT_THRESHOLD};
  always_comb
  begin
    stat_w = '0;
    stat_w[STAT_ST_LSB +: 3] = state_r;
    stat_w[STAT_FLOOR_B] = floor_flag_r;
    stat_w[STAT_SUPP_B] = supp_r;
    stat_w[STAT_DFLT_B] = dflt_r;
    stat_w[STAT_HALF_B] = half_r;
    rdy_nxt = psel_i & penable_i & !rdy_r;
    err_nxt = rdy_nxt & !mapped;
    rdata_nxt = rdata_r;
    if (rdy_nxt)
      case (paddr_i)
        OFS_CTRL: rdata_nxt = {29'h0, ctrl_r};
        OFS_FLOOR: rdata_nxt = {28'h0, floor_r};
        OFS_STAT: rdata_nxt = stat_w;
        OFS_FAULT: rdata_nxt = {30'h0, fault_r};
        OFS_TERMINATION_CURRENT_THRESHOLD: rdata_nxt = {25'h0, termination_current_threshold_r};
        default: rdata_nxt = '0;
      endcase
    ctrl_nxt = ctrl_r;
    floor_nxt = floor_r;
    termination_current_threshold_nxt = termination_current_threshold_r;
    if (hw_rst)
    begin
      ctrl_nxt = CTRL_RST;
      floor_nxt = FLOOR_RST;
      termination_current_threshold_nxt = TERMINATION_CURRENT_THRESHOLD_RST;
    end
    else if (wr_go)
      case (paddr_i)
        OFS_CTRL: ctrl_nxt = pwdata_i[2:0];
        OFS_FLOOR: floor_nxt = pwdata_i[3:0];
        OFS_TERMINATION_CURRENT_THRESHOLD: termination_current_threshold_nxt = pwdata_i[TERMINATION_CURRENT_THRESHOLD_W-1:0];
        default: ctrl_nxt = ctrl_r;
      endcase
    // Entry by power-on of input or reset bit wins over the exit write
    dflt_nxt = dflt_r & !wr_go;
    if (hw_rst || (valid && !valid_r))
      dflt_nxt = 1'b1;
  end
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= CTRL_RST;
      floor_r <= FLOOR_RST;
      termination_current_threshold_r <= TERMINATION_CURRENT_THRESHOLD_RST;
      dflt_r <= 1'b1;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= '0;
    end
    else if (ce_i)
    begin
      ctrl_r <= ctrl_nxt;
      floor_r <= floor_nxt;
      termination_current_threshold_r <= termination_current_threshold_nxt;
      dflt_r <= dflt_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign pready_o = rdy_r;
  assign pslverr_o = err_r;
  assign prdata_o = rdata_r;

  // Charge state machine, loop tracking and supplement
  logic floor_en, floor_block, inhibit, charging, cv_only, term_ok;
  logic dbl, supp_nxt, floor_flag, half, ext;
  loop_type loop_nxt;
  assign dbl = ctrl_r[CTRL_DBL_B];
  assign floor_en = floor_r[FLOOR_EN_B];
  assign floor_block = floor_en & f_r[IN_FLOW];
  assign valid = input_undervoltage_fault_ok & f_r[IN_SLEEP] & !ovp_act_r & !input_undervoltage_fault_act_r
    & !floor_block;
  assign inhibit = ctrl_r[CTRL_INH_B] | f_r[IN_CD];
  assign charging = state_r == ST_CC || state_r == ST_CV;
  assign floor_flag = floor_en & floor_l & charging;
  assign half = dbl & charging & (input_limit_setting_l | floor_l);
  assign ext = dbl & floor_flag;
  // Any loop but CV, or supplement, holds termination off
  // Entry comparator blocks too, so no end slips in before supp_r sets
  assign cv_only = !input_limit_setting_l & !floor_l & !supp_r & !supp_in;
  assign term_ok = ctrl_r[CTRL_TEN_B] & cv_only & f_r[IN_TERMINATION_CURRENT_THRESHOLD]
    & f_r[IN_RECHG];
  always_comb
  begin
    supp_nxt = supp_r;
    if (supp_in)
      supp_nxt = 1'b1;
    else if (supp_out)
      supp_nxt = 1'b0;
    state_nxt = state_r;
    case (state_r)
      ST_NOIN:
        if (valid)
          state_nxt = inhibit ? ST_INH : ST_CC;
      ST_INH:
        if (!valid)
          state_nxt = ST_NOIN;
        else if (!inhibit)
          state_nxt = ST_CC;
      ST_CC:
        if (!valid)
          state_nxt = ST_NOIN;
        else if (inhibit)
          state_nxt = ST_INH;
        else if (f_r[IN_BREG])
          state_nxt = ST_CV;
      ST_CV:
        if (!valid)
          state_nxt = ST_NOIN;
        else if (inhibit)
          state_nxt = ST_INH;
        else if (term_ok)
          state_nxt = ST_DONE;
      ST_DONE:
        if (!valid)
          state_nxt = ST_NOIN;
        else if (inhibit)
          state_nxt = ST_INH;
        else if (!f_r[IN_RECHG])
          state_nxt = ST_CC;
      ST_FAULT:
        if (!ovp_act_r)
          state_nxt = ST_NOIN;
      default: state_nxt = ST_NOIN;
    endcase
    if (ovp_act_r)
      state_nxt = ST_FAULT;
    // Lowest-current loop governs; floor and limit override CC and CV
    if (floor_l)
      loop_nxt = LP_FLOOR;
    else if (input_limit_setting_l)
      loop_nxt = LP_INPUT_LIMIT_SETTING;
    else if (state_r == ST_CV)
      loop_nxt = LP_CV;
    else
      loop_nxt = LP_CC;
  end
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_NOIN;
      supp_r <= 1'b0;
      valid_r <= 1'b0;
      floor_flag_r <= 1'b0;
      half_r <= 1'b0;
      charge_en_o <= 1'b0;
      discharge_sw_o <= 1'b1;
      timer_extend_o <= 1'b0;
      loop_o <= LP_CC;
      floor_en_o <= 1'b0;
      floor_code_o <= '0;
      term_ua_o <= '0;
      precharge_ua_o <= '0;
      term_pct_o <= '0;
      use_reg_fast_charge_setting_o <= 1'b1;
      use_reg_input_limit_setting_o <= 1'b1;
      use_reg_termination_current_threshold_o <= 1'b1;
    end
    else if (ce_i)
    begin
      state_r <= state_nxt;
      supp_r <= supp_nxt;
      valid_r <= valid;
      floor_flag_r <= floor_flag;
      half_r <= half;
      charge_en_o <= state_nxt == ST_CC || state_nxt == ST_CV;
      // Battery feeds the mid rail unless a clean input carries it
      discharge_sw_o <= ovp_act_r | !valid | supp_r;
      timer_extend_o <= ext;
      loop_o <= loop_nxt;
      floor_en_o <= floor_en;
      floor_code_o <= floor_r[FLOOR_W-1:0];
      term_ua_o <= termination_current_threshold_ua(termination_current_threshold_r);
      precharge_ua_o <= termination_current_threshold_ua(termination_current_threshold_r);
      term_pct_o <= pct_of(f_r[IN_PCT +: 2]);
      use_reg_fast_charge_setting_o <= !dflt_r | f_r[IN_GSET];
      use_reg_input_limit_setting_o <= !dflt_r | f_r[IN_GLIM];
      use_reg_termination_current_threshold_o <= !dflt_r | f_r[IN_GTRM];
    end
  end
  assign timer_half_o = half_r;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [CNT_W-1:0] ilen_r;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      ilen_r <= '0;
    else if (ce_i)
      ilen_r <= int_o ? ilen_r + 1'b1 : '0;
  end
  sequence s_enter_done;
    state_r != ST_DONE ##1 state_r == ST_DONE;
  endsequence
  sequence s_ovp_leave;
    state_r == ST_FAULT ##1 state_r != ST_FAULT;
  endsequence
  chk_pulse_len: assert property ($fell(int_o) |->
    ilen_r == CNT_W'(PULSE_CYC))
    else $error("interrupt pulse length wrong");
  chk_pulse_max: assert property (ilen_r <= CNT_W'(PULSE_CYC))
    else $error("interrupt pulse stretched");
  chk_ovp_discharge: assert property ((ce_i && ovp_act_r) |=>
    discharge_sw_o)
    else $error("discharge switch off during overvoltage");
  chk_term_gate: assert property (s_enter_done |->
    $past(cv_only && state_r == ST_CV))
    else $error("termination outside pure CV");
  chk_ovp_clear: assert property (s_ovp_leave |->
    !ovp_act_r && state_r == ST_NOIN)
    else $error("fault state left wrongly");
  chk_fault_hold: assert property ((ce_i && rd_fault && ovp_s &&
    fault_r[FLT_OVP_B]) |=> fault_r[FLT_OVP_B])
    else $error("fault flag cleared while cause present");
  chk_inhibit_off: assert property ((ce_i && state_nxt == ST_INH) |=>
    !charge_en_o && state_r == ST_INH)
    else $error("charging while inhibited");
  chk_default_exit: assert property ((ce_i && wr_go && !hw_rst &&
    !(valid && !valid_r)) |=> !dflt_r)
    else $error("default mode kept after write");
  chk_supp_exit: assert property ((ce_i && supp_r && !supp_in &&
    supp_out) |=> !supp_r)
    else $error("supplement not left");
  chk_half_rate: assert property ((ce_i && dbl && charging && input_limit_setting_l)
    |=> timer_half_o)
    else $error("timer not at half rate");
  chk_floor_flag: assert property ((ce_i && floor_flag) |=>
    floor_flag_r)
    else $error("floor flag not set");
endmodule // charge_ctrl

/* File: testbench/battery_model.sv */
// Battery model whose voltage climbs in steps while charge is on
`timescale 1ns/1ps
module battery_model
#(
  parameter int STEP_CYC = 8
)
(
  input wire logic mclk_i,
  input wire logic charge_en_i,
  output logic bat_at_reg_o,
  output logic ichg_at_term_o,
  output logic bat_above_rechg_o
);
  int level_r = 0;
  int tick_r = 0;
  // Coarse steps keep each comparator stable well past the synchroniser
  always_ff @(posedge mclk_i)
  begin
    if (charge_en_i && level_r < 40)
    begin
      tick_r <= (tick_r == STEP_CYC - 1) ? 0 : tick_r + 1;
      if (tick_r == STEP_CYC - 1)
        level_r <= level_r + 1;
    end
  end
  // No load is modelled, so a full battery never sags to recharge
  assign bat_above_rechg_o = (level_r >= 4);
  assign bat_at_reg_o = (level_r >= 16);
  assign ichg_at_term_o = (level_r >= 24);
endmodule // battery_model

/* File: testbench/tb_charge_control_fault_logic.sv */
// Register-level test sequence for the charge control block
`timescale 1ns/1ps
module tb_charge_control_fault_logic;
  import chg_pkg::*;
  localparam int unsigned PULSE_N = 32'h8;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic input_undervoltage_fault_ok = 1'b1;
  logic input_overvoltage_fault = 1'b0;
  logic input_limit_setting_loop = 1'b0;
  logic floor_loop = 1'b0;
  logic cd_pin = 1'b1;
  logic sup_in = 1'b0;
  logic sup_out = 1'b0;
  logic [1:0] pct_sel = 2'h0;
  logic ce = 1'b1;
  logic sleep_ok = 1'b1;
  logic below_floor = 1'b0;
  logic [2:0] gnd = 3'h5;
  logic [31:0] prdata;
  logic [31:0] d;
  logic pready;
  logic pslverr;
  logic err;
  logic charge_en;
  logic dis_sw;
  logic int_pulse;
  logic t_half;
  logic t_ext;
  logic floor_en;
  logic bat_reg;
  logic at_term;
  logic above_rechg;
  loop_type loop;
  logic [2:0] floor_code;
  logic [15:0] term_ua;
  logic [15:0] pre_ua;
  logic [4:0] pct;
  logic [2:0] use_reg;
  logic [6:0] codes [3] = '{7'h00, 7'h49, 7'h7F};
  int errors = 0;
  int checks_done = 0;
  int n;

  always #2.5 mclk_i = ~mclk_i;

  charge_ctrl #(.PULSE_CYC(8), .OVP_DGL_CYC(5), .INPUT_UNDERVOLTAGE_FAULT_DGL_CYC(5)) u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .vin_input_undervoltage_fault_ok_i(input_undervoltage_fault_ok),
    .vin_sleep_ok_i(sleep_ok),
    .input_overvoltage_fault_i(input_overvoltage_fault), .vin_below_floor_i(below_floor),
    .bat_at_reg_i(bat_reg), .ichg_at_term_i(at_term),
    .bat_above_rechg_i(above_rechg), .mid_below_sup_entry_i(sup_in),
    .mid_above_sup_exit_i(sup_out), .input_limit_setting_loop_i(input_limit_setting_loop),
    .floor_loop_i(floor_loop), .charge_disable_pin_i(cd_pin),
    .fast_charge_setting_gnd_i(gnd[2]), .input_limit_setting_gnd_i(gnd[1]), .termination_current_threshold_gnd_i(gnd[0]),
    .term_pct_sel_i(pct_sel), .charge_en_o(charge_en),
    .discharge_sw_o(dis_sw), .int_o(int_pulse), .timer_half_o(t_half),
    .timer_extend_o(t_ext), .loop_o(loop), .floor_en_o(floor_en),
    .floor_code_o(floor_code), .term_ua_o(term_ua),
    .precharge_ua_o(pre_ua), .term_pct_o(pct),
    .use_reg_fast_charge_setting_o(use_reg[2]), .use_reg_input_limit_setting_o(use_reg[1]),
    .use_reg_termination_current_threshold_o(use_reg[0]));

  battery_model u_bat (
    .mclk_i(mclk_i), .charge_en_i(charge_en), .bat_at_reg_o(bat_reg),
    .ichg_at_term_o(at_term), .bat_above_rechg_o(above_rechg));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge mclk_i);
  endtask

  // Request held until pready is seen high or 20 cycles pass; no latency is assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      errors++;
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
    wt(2);
  endtask

  task automatic count_int(input int c);
    n = 0;
    repeat (c)
    begin
      @(posedge mclk_i);
      if (int_pulse === 1'b1)
        n++;
    end
  endtask

  task automatic endtest(input string name);
    $display("test %s finished", name);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [31:0] ua(input logic [6:0] c);
    ua = ((c > TERMINATION_CURRENT_THRESHOLD_MAX) ? 32'h4A : 32'(c) + 32'h1) * 32'(TERMINATION_CURRENT_THRESHOLD_STEP_UA);
  endfunction

  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    wt(10);
    rd(OFS_CTRL);
    check("ctrl", d, 32'h4);
    rd(OFS_FLOOR);
    check("floor", d, 32'h0);
    check("floor_en", floor_en, 1'b0);
    rd(OFS_TERMINATION_CURRENT_THRESHOLD);
    check("termination_current_threshold", d, 32'h13);
    check("term_ua", term_ua, 32'h2710);
    check("pre_ua", pre_ua, 32'h2710);
    rd(OFS_STAT);
    check("dflt", d[STAT_DFLT_B], 1'b1);
    check("use_reg", use_reg, 3'h5);
    gnd <= 3'h2;
    wt(8);
    check("use_reg_gnd", use_reg, 3'h2);
    rd(8'h14);
    check("slverr", err, 1'b1);
    check("unmapped", d, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      pct_sel <= 2'(i);
      wt(8);
      check("pct", pct, PCT_STEP * (i + 1));
    end
    ce <= 1'b0;
    pct_sel <= 2'h0;
    wt(8);
    check("pct_frozen", pct, 32'h14);
    ce <= 1'b1;
    wt(8);
    check("pct_run", pct, 32'h5);
    endtest("defaults");
    foreach (codes[i])
    begin
      wr(OFS_TERMINATION_CURRENT_THRESHOLD, {25'h0, codes[i]});
      check("term", term_ua, ua(codes[i]));
      check("pre", pre_ua, ua(codes[i]));
    end
    wr(OFS_TERMINATION_CURRENT_THRESHOLD, {25'h0, TERMINATION_CURRENT_THRESHOLD_RST});
    check("term_pin", term_ua, 32'h2710);
    rd(OFS_STAT);
    check("host", d[STAT_DFLT_B], 1'b0);
    check("use_host", use_reg, 3'h7);
    wr(OFS_CTRL, 32'h8);
    rd(OFS_STAT);
    check("dflt_again", d[STAT_DFLT_B], 1'b1);
    rd(OFS_TERMINATION_CURRENT_THRESHOLD);
    check("termination_current_threshold_rst", d, 32'h13);
    endtest("modes");
    wr(OFS_FLOOR, 32'hD);
    check("floor_on", floor_en, 1'b1);
    check("floor_code", floor_code, 3'h5);
    wr(OFS_CTRL, 32'h5);
    cd_pin <= 1'b0;
    wt(8);
    check("chg_inh", charge_en, 1'b0);
    check("dis_inh", dis_sw, 1'b0);
    below_floor <= 1'b1;
    wt(8);
    rd(OFS_STAT);
    check("st_blk", d[2:0], ST_NOIN);
    check("dis_blk", dis_sw, 1'b1);
    below_floor <= 1'b0;
    wt(8);
    rd(OFS_STAT);
    check("st_inh", d[2:0], ST_INH);
    wr(OFS_CTRL, 32'h6);
    wt(8);
    check("chg_on", charge_en, 1'b1);
    check("loop_cc", loop, LP_CC);
    rd(OFS_STAT);
    check("st_cc", d[2:0], ST_CC);
    floor_loop <= 1'b1;
    wt(8);
    rd(OFS_STAT);
    check("floor_flag", d[STAT_FLOOR_B], 1'b1);
    check("extend", t_ext, 1'b1);
    check("loop_fl", loop, LP_FLOOR);
    floor_loop <= 1'b0;
    cd_pin <= 1'b1;
    wt(8);
    check("chg_cd", charge_en, 1'b0);
    cd_pin <= 1'b0;
    input_limit_setting_loop <= 1'b1;
    wt(250);
    check("chg_input_limit_setting", charge_en, 1'b1);
    check("loop_il", loop, LP_INPUT_LIMIT_SETTING);
    check("half", t_half, 1'b1);
    sup_in <= 1'b1;
    input_limit_setting_loop <= 1'b0;
    wt(10);
    rd(OFS_STAT);
    check("st_cv", d[2:0], ST_CV);
    check("supp", d[STAT_SUPP_B], 1'b1);
    sup_in <= 1'b0;
    sup_out <= 1'b1;
    wt(10);
    rd(OFS_STAT);
    check("st_done", d[2:0], ST_DONE);
    check("chg_done", charge_en, 1'b0);
    endtest("charge");
    input_overvoltage_fault <= 1'b1;
    count_int(40);
    check("ovp_pulse", 32'(n), PULSE_N);
    check("ovp_dis", dis_sw, 1'b1);
    rd(OFS_FAULT);
    check("flt_hold", d, 32'h1);
    rd(OFS_FAULT);
    check("flt_hold2", d, 32'h1);
    input_overvoltage_fault <= 1'b0;
    wt(20);
    rd(OFS_FAULT);
    check("flt_last", d, 32'h1);
    rd(OFS_FAULT);
    check("flt_clr", d, 32'h0);
    endtest("overvoltage");
    input_undervoltage_fault_ok <= 1'b0;
    n = 0;
    while (int_pulse !== 1'b1 && n < 40)
    begin
      @(posedge mclk_i);
      n++;
    end
    // Second fault lands inside the running pulse
    input_overvoltage_fault <= 1'b1;
    count_int(40);
    check("uv_pulse", 32'(n + 1), PULSE_N);
    rd(OFS_FAULT);
    check("uv_flt", d, 32'h3);
    endtest("undervoltage");
    complete_run();
  end

  initial
  begin
    #20000;
    errors++;
    complete_run();
  end
endmodule // tb_charge_control_fault_logic
